/* File: ubs_consts.vh */
`ifndef UBS_CONSTS_VH
`define UBS_CONSTS_VH

// ============================================================
// Register byte offsets
`define UBS_ADDR_CTRL 8'h00
`define UBS_ADDR_BUFCTRL 8'h04
`define UBS_ADDR_STATUS 8'h08
`define UBS_ADDR_RXDATA 8'h0c

// ============================================================
// Control register field positions
`define UBS_CTRL_DOUBLE 0
`define UBS_CTRL_LOWSPD 1
`define UBS_CTRL_OVR_EN 2
`define UBS_CTRL_OVR_DP 3
`define UBS_CTRL_OVR_DM 4
`define UBS_CTRL_W 5
`define UBS_CTRL_RESET 5'h00

// ============================================================
// Status register field positions
`define UBS_ST_CONNECTED 0
`define UBS_ST_BUF_SEL 1
`define UBS_ST_DONE_SEL 2
`define UBS_ST_BUF_DONE 3
`define UBS_ST_RX_DROP 4
`define UBS_ST_RX_AVAIL 5

// ============================================================
// Buffer control word layout and reset value
`define UBS_HALF_W 16
`define UBS_SECOND_LSB 16
`define UBS_BUFCTRL_RESET 32'h0000_0000

// ============================================================
// Packet sizes in bytes
`define UBS_MAXPKT_LS 11'h008
`define UBS_MAXPKT_FS 11'h040

// ============================================================
// Timing: clock period, idle window and reset detection
`define UBS_CLK_PERIOD_NS 5
`define UBS_IDLE_J_US 800
`define UBS_IDLE_J_CYCLES ((`UBS_IDLE_J_US * 1000 + `UBS_CLK_PERIOD_NS - 1) / `UBS_CLK_PERIOD_NS)
`define UBS_SE0_DETECT_NS 2500
`define UBS_SE0_CYCLES ((`UBS_SE0_DETECT_NS + `UBS_CLK_PERIOD_NS - 1) / `UBS_CLK_PERIOD_NS)

`endif

/* File: ubs_buf2.v */
`timescale 1ns/1ps
`include "ubs_consts.vh"

// ============================================================
// Two-entry buffer with valid and ready on both sides.
module ubs_buf2 #(
   parameter W = 8
) (
   input wire clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);

   // Storage entries, held in flip-flops.
   reg [W-1:0] mem [0:1];
   // Write and read indices.
   reg wr_idx;
   reg rd_idx;
   // Number of entries held, zero to two.
   reg [1:0] count;

   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // Full and empty follow the entry count directly.
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_idx];

   // ============================================================
   // Index and count update.
   always @(posedge clk) begin
      if (rst) begin
         wr_idx <= 1'b0;
         rd_idx <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            wr_idx <= ~wr_idx;
         end
         if (pop) begin
            rd_idx <= ~rd_idx;
         end
         if (push & ~pop) begin
            count <= count + 2'h1;
         end else if (pop & ~push) begin
            count <= count - 2'h1;
         end
      end
   end

   // Entry write; storage needs no reset.
   always @(posedge clk) begin
      if (push) begin
         mem[wr_idx] <= in_data;
      end
   end

endmodule

/* File: ubs_ctrl.v */
`timescale 1ns/1ps
`include "ubs_consts.vh"

// ============================================================
// Buffer selector, status write-back and reset exit logic.
module ubs_ctrl #(
   parameter [17:0] IDLE_CYCLES = `UBS_IDLE_J_CYCLES,
   parameter DW = 8
) (
   input wire clk,
   input wire rst,
   // Register port.
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   // Line pins, asynchronous to clk.
   input wire dp_pin,
   input wire dm_pin,
   // Host transaction engine.
   input wire hc_txn_start,
   input wire [10:0] hc_txn_len,
   input wire hc_pkt_done,
   input wire [15:0] hc_pkt_status,
   output reg [15:0] hc_buf_info,
   output wire hc_buf_sel,
   output reg hc_buf_done,
   // Device receive path.
   input wire rx_valid,
   output wire rx_ready,
   input wire [DW-1:0] rx_data,
   output wire connected
);

   // ============================================================
   // State codes for the device link, one-hot.
   localparam [1:0] ST_RESET = 2'b01;
   localparam [1:0] ST_CONN = 2'b10;
   // Reset detection length in cycles, cut on purpose to the counter width.
   localparam [31:0] SE0_FULL = `UBS_SE0_CYCLES;
   localparam [9:0] SE0_CYCLES = SE0_FULL[9:0];

   // Control register.
   reg [`UBS_CTRL_W-1:0] ctrl;
   // Buffer control word holding both halves.
   reg [31:0] bufctrl;
   // Current buffer selector, zero is the first buffer.
   reg buf_sel;
   // Selector value captured at the last completion.
   reg done_buffer_select_status;
   // Sticky completion flag, write one to clear.
   reg buf_done;
   // Sticky flag for packets refused before connection.
   reg rx_drop;
   // Bytes still to move in the current host transaction.
   reg [10:0] txn_left;
   // Device link state.
   reg [1:0] state;
   // Counter of continuous idle J cycles.
   reg [17:0] idle_cnt;
   // Counter of continuous SE0 cycles.
   reg [9:0] se0_cnt;
   // Two-stage synchronisers for the pins.
   reg dp_s1;
   reg dp_s2;
   reg dm_s1;
   reg dm_s2;

   wire dbl = ctrl[`UBS_CTRL_DOUBLE];
   wire [10:0] maxpkt = ctrl[`UBS_CTRL_LOWSPD] ? `UBS_MAXPKT_LS : `UBS_MAXPKT_FS;
   wire wr_ctrl = wr & (addr == `UBS_ADDR_CTRL);
   wire wr_buf = wr & (addr == `UBS_ADDR_BUFCTRL);
   wire wr_stat = wr & (addr == `UBS_ADDR_STATUS);
   wire rd_rx = rd & (addr == `UBS_ADDR_RXDATA);

   // ============================================================
   // Pin synchronisers; the first stage feeds only the second.
   always @(posedge clk) begin
      if (rst) begin
         dp_s1 <= 1'b0;
         dp_s2 <= 1'b0;
         dm_s1 <= 1'b0;
         dm_s2 <= 1'b0;
      end else begin
         dp_s1 <= dp_pin;
         dp_s2 <= dp_s1;
         dm_s1 <= dm_pin;
         dm_s2 <= dm_s1;
      end
   end

   // line input override
   // The override replaces the pin level seen by the controller.
   wire dp_line = ctrl[`UBS_CTRL_OVR_EN] ? ctrl[`UBS_CTRL_OVR_DP] : dp_s2;
   wire dm_line = ctrl[`UBS_CTRL_OVR_EN] ? ctrl[`UBS_CTRL_OVR_DM] : dm_s2;

   // full speed J
   // Idle J is the positive line high and the negative line low.
   wire line_j = dp_line & ~dm_line;
   // Single-ended zero has both lines low.
   wire line_se0 = ~dp_line & ~dm_line;

   // ============================================================
   // Control register write.
   always @(posedge clk) begin
      if (rst) begin
         ctrl <= `UBS_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= wdata[`UBS_CTRL_W-1:0];
      end
   end

   // ============================================================
   // SE0 length counter, saturating at the detection length.
   always @(posedge clk) begin
      if (rst) begin
         se0_cnt <= 10'h000;
      end else if (!line_se0) begin
         se0_cnt <= 10'h000;
      end else if (se0_cnt != SE0_CYCLES) begin
         se0_cnt <= se0_cnt + 10'h001;
      end
   end

   wire se0_seen = (se0_cnt == SE0_CYCLES);

   // ============================================================
   // Device link state machine.
   always @(posedge clk) begin
      if (rst) begin
         state <= ST_RESET;
         idle_cnt <= 18'h00000;
      end else begin
         case (state)
            ST_RESET: begin
               // idle window count
               // Any non-idle line state restarts the window.
               if (!line_j) begin
                  idle_cnt <= 18'h00000;
               end else if (idle_cnt == IDLE_CYCLES - 18'h00001) begin
                  idle_cnt <= 18'h00000;
                  state <= ST_CONN;
               end else begin
                  idle_cnt <= idle_cnt + 18'h00001;
               end
            end
            ST_CONN: begin
               // enter reset
               // A host reset returns the link to RESET.
               idle_cnt <= 18'h00000;
               if (se0_seen) begin
                  state <= ST_RESET;
               end
            end
            default: begin
               state <= ST_RESET;
               idle_cnt <= 18'h00000;
            end
         endcase
      end
   end

   assign connected = (state == ST_CONN);

   // ============================================================
   // Receive buffer; the head is read through the data register.
   wire buf_in_ready;
   wire buf_out_valid;
   wire [DW-1:0] buf_out_data;

   // refuse before connect
   // Before connection bytes are taken and discarded.
   wire rx_keep = rx_valid & connected;
   assign rx_ready = connected ? buf_in_ready : 1'b1;

   ubs_buf2 #(
      .W(DW)
   ) u_rxbuf (
      .clk(clk),
      .rst(rst),
      .in_valid(rx_keep),
      .in_ready(buf_in_ready),
      .in_data(rx_data),
      .out_valid(buf_out_valid),
      .out_ready(rd_rx),
      .out_data(buf_out_data)
   );

   // ============================================================
   // Refused packet flag; a new refusal wins over a clear.
   always @(posedge clk) begin
      if (rst) begin
         rx_drop <= 1'b0;
      end else if (rx_valid & ~connected) begin
         rx_drop <= 1'b1;
      end else if (wr_stat & wdata[`UBS_ST_RX_DROP]) begin
         rx_drop <= 1'b0;
      end
   end

   // ============================================================
   // Host transaction tracking.
   // A packet is the last of its buffer when no more than one
   // maximum sized packet of bytes remains.
   wire last_pkt = (txn_left <= maxpkt);

   always @(posedge clk) begin
      if (rst) begin
         txn_left <= 11'h000;
      end else if (hc_txn_start) begin
         txn_left <= hc_txn_len;
      end else if (hc_pkt_done) begin
         txn_left <= last_pkt ? 11'h000 : (txn_left - maxpkt);
      end
   end

   // ============================================================
   // Buffer selector.
   always @(posedge clk) begin
      if (rst) begin
         buf_sel <= 1'b0;
      end else if (dbl) begin
         // double buffered toggle
         // Each completed packet moves to the other buffer.
         if (hc_pkt_done) begin
            buf_sel <= ~buf_sel;
         end
      end else begin
         // single buffered hold
         // The selector is held at the first buffer.
         buf_sel <= 1'b0;
      end
   end

   assign hc_buf_sel = buf_sel;

   // single buffered write-back
   // Status lands in the first half unless double buffered with the second buffer selected.
   wire wb_second = dbl & buf_sel;

   // ============================================================
   // Buffer control word; hardware write-back wins over software.
   always @(posedge clk) begin
      if (rst) begin
         bufctrl <= `UBS_BUFCTRL_RESET;
      end else begin
         if (wr_buf) begin
            bufctrl <= wdata;
         end
         // half layout
         // The second buffer sits sixteen bits above the first.
         if (hc_pkt_done) begin
            if (wb_second) begin
               bufctrl[`UBS_SECOND_LSB +: `UBS_HALF_W] <= hc_pkt_status;
            end else begin
               bufctrl[0 +: `UBS_HALF_W] <= hc_pkt_status;
            end
         end
      end
   end

   // ============================================================
   // Buffer information fetch for the next packet.
   always @(posedge clk) begin
      if (rst) begin
         hc_buf_info <= 16'h0000;
      end else if (hc_txn_start | hc_pkt_done) begin
         // single buffered fetch
         // The selector matters only in double buffered mode.
         if (dbl & (hc_pkt_done ? ~buf_sel : buf_sel)) begin
            hc_buf_info <= bufctrl[`UBS_SECOND_LSB +: `UBS_HALF_W];
         end else begin
            hc_buf_info <= bufctrl[0 +: `UBS_HALF_W];
         end
      end
   end

   // ============================================================
   // Completion record and done flag.
   wire buf_complete = hc_pkt_done & (dbl | last_pkt);

   always @(posedge clk) begin
      if (rst) begin
         done_buffer_select_status <= 1'b0;
         buf_done <= 1'b0;
         hc_buf_done <= 1'b0;
      end else begin
         hc_buf_done <= buf_complete;
         // record selector
         // The half that completed is kept for software.
         if (buf_complete) begin
            done_buffer_select_status <= wb_second;
         end
         // A completion wins over a clear in the same cycle.
         if (buf_complete) begin
            buf_done <= 1'b1;
         end else if (wr_stat & wdata[`UBS_ST_BUF_DONE]) begin
            buf_done <= 1'b0;
         end
      end
   end

   // ============================================================
   // Register read data, valid in the cycle after the strobe.
   always @(posedge clk) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         case (addr)
            `UBS_ADDR_CTRL: begin
               rdata <= {{(32 - `UBS_CTRL_W){1'b0}}, ctrl};
            end
            `UBS_ADDR_BUFCTRL: begin
               rdata <= bufctrl;
            end
            `UBS_ADDR_STATUS: begin
               rdata <= {26'h0000000, buf_out_valid, rx_drop, buf_done,
                         done_buffer_select_status, buf_sel, connected};
            end
            `UBS_ADDR_RXDATA: begin
               // An empty buffer reads as zero and pops nothing.
               rdata <= buf_out_valid ? {{(32 - DW){1'b0}}, buf_out_data} : 32'h0000_0000;
            end
            default: begin
               rdata <= 32'h0000_0000;
            end
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

endmodule

/* File: ubs_ctrl_chk.sv */
`timescale 1ns/1ps
`include "ubs_consts.vh"

// ============================================================
// Port checker for the selector, receive gate and link state.
module ubs_ctrl_chk #(
   parameter [17:0] IDLE_CYCLES = 18'd20,
   parameter DW = 8
) (
   input wire clk,
   input wire rst,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire [31:0] rdata,
   input wire dp_pin,
   input wire dm_pin,
   input wire hc_txn_start,
   input wire [10:0] hc_txn_len,
   input wire hc_pkt_done,
   input wire [15:0] hc_pkt_status,
   input wire [15:0] hc_buf_info,
   input wire hc_buf_sel,
   input wire hc_buf_done,
   input wire rx_valid,
   input wire rx_ready,
   input wire [DW-1:0] rx_data,
   input wire connected
);
   // Shadow of the control bits, two-flop copies of the pins, run counters.
   reg [4:0] ctl;
   reg [1:0] dp_s;
   reg [1:0] dm_s;
   reg [19:0] jcnt;
   reg [9:0] zcnt;
   // Line level as the design sees it, override applied after the sync.
   wire dp_l = ctl[2] ? ctl[3] : dp_s[1];
   wire dm_l = ctl[2] ? ctl[4] : dm_s[1];

   // Tracks control writes and counts idle and zero runs on the line.
   // The pin copies clear in reset, as the design's synchronisers do.
   always @(posedge clk) begin
      if (rst) begin
         dp_s <= 2'h0;
         dm_s <= 2'h0;
         ctl <= 5'h00;
         jcnt <= 20'h0;
         zcnt <= 10'h0;
      end else begin
         dp_s <= {dp_s[0], dp_pin};
         dm_s <= {dm_s[0], dm_pin};
         if (wr && addr == `UBS_ADDR_CTRL) begin
            ctl <= wdata[4:0];
         end
         jcnt <= (connected || !(dp_l && !dm_l)) ? 20'h0 : jcnt + 20'h1;
         zcnt <= (dp_l || dm_l) ? 10'h0 : ((zcnt == 10'h3ff) ? zcnt : zcnt + 10'h1);
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ============================================================
   // Assertions
   a_single_sel_low: assert property (!ctl[0] |=> !hc_buf_sel)
      else $error("selector left on second buffer in single mode");
   a_double_toggle: assert property (ctl[0] && hc_pkt_done |=> hc_buf_sel != $past(hc_buf_sel))
      else $error("selector did not alternate in double mode");
   a_double_done: assert property (ctl[0] && hc_pkt_done |=> hc_buf_done)
      else $error("double buffered packet gave no completion");
   a_done_cause: assert property (hc_buf_done |-> $past(hc_pkt_done))
      else $error("completion pulse without a finished packet");
   a_rx_discard: assert property (!connected |-> rx_ready)
      else $error("receive stalled while not connected");
   a_connect_early: assert property ($rose(connected) |-> jcnt >= IDLE_CYCLES - 1)
      else $error("connected before the full idle window");
   a_connect_late: assert property (jcnt == IDLE_CYCLES + 2 |-> connected)
      else $error("idle window passed without connecting");
   a_se0_enter: assert property (zcnt == `UBS_SE0_CYCLES + 2 |-> !connected)
      else $error("held zero did not return the link to reset");
   a_se0_early: assert property ($fell(connected) |-> zcnt >= `UBS_SE0_CYCLES - 1)
      else $error("link left connected without a held zero");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside the answer cycle");

   c_connect: cover property ($rose(connected));
   c_disconnect: cover property ($fell(connected));
   c_second_done: cover property (ctl[0] && hc_buf_done && !hc_buf_sel);
endmodule

bind ubs_ctrl ubs_ctrl_chk #(.IDLE_CYCLES(IDLE_CYCLES), .DW(DW)) u_chk (.clk(clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dp_pin(dp_pin), .dm_pin(dm_pin),
   .hc_txn_start(hc_txn_start), .hc_txn_len(hc_txn_len), .hc_pkt_done(hc_pkt_done),
   .hc_pkt_status(hc_pkt_status), .hc_buf_info(hc_buf_info), .hc_buf_sel(hc_buf_sel),
   .hc_buf_done(hc_buf_done), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
   .connected(connected));

/* File: ubs_host_model.sv */
`timescale 1ns/1ps

// ============================================================
// Far end of the link: idle, held zero or traffic for other devices.
module ubs_host_model (
   input wire clk,
   input wire [1:0] mode,
   output reg dp,
   output reg dm
);
   // Phase counter; busy traffic keeps idle runs far shorter than the window.
   reg [2:0] ph = 3'h0;

   always @(posedge clk) begin
      ph <= ph + 3'h1;
      dp <= (mode == 2'h0) || (mode == 2'h2 && ph[2]);
      dm <= (mode == 2'h2 && !ph[2]);
   end
endmodule

/* File: ubs_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "ubs_consts.vh"

// ============================================================
// Bench top: drives the register port, host engine and receive path.
module ubs_ctrl_tb_top;
   localparam [17:0] IDLE_N = 18'd20;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg hc_txn_start = 1'b0;
   reg [10:0] hc_txn_len = 11'h0;
   reg hc_pkt_done = 1'b0;
   reg [15:0] hc_pkt_status = 16'h0;
   reg rx_valid = 1'b0;
   reg [7:0] rx_data = 8'h00;
   reg [1:0] mode = 2'h1;
   wire [31:0] rdata;
   wire [15:0] hc_buf_info;
   wire hc_buf_sel, hc_buf_done, rx_ready, connected, dp, dm;
   integer fail_count = 0;
   integer checked = 0;

   ubs_ctrl #(.IDLE_CYCLES(IDLE_N), .DW(8)) u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .dp_pin(dp), .dm_pin(dm), .hc_txn_start(hc_txn_start),
      .hc_txn_len(hc_txn_len), .hc_pkt_done(hc_pkt_done), .hc_pkt_status(hc_pkt_status),
      .hc_buf_info(hc_buf_info), .hc_buf_sel(hc_buf_sel), .hc_buf_done(hc_buf_done),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .connected(connected));
   ubs_host_model u_host (.clk(clk), .mode(mode), .dp(dp), .dm(dm));

   // Free running 200 MHz clock.
   initial begin
      forever #2.5 clk = ~clk;
   end

   // ============================================================
   // Shared tasks
   task end_sim;
      begin
         $display("checked %0d fail_count %0d", checked, fail_count);
         if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task cmp(input [8*12-1:0] name, input [31:0] exp, input [31:0] got);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task wreg(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         wr <= 1'b1; addr <= a; wdata <= d;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rchk(input [7:0] a, input [31:0] exp, input [8*12-1:0] name);
      begin
         @(posedge clk);
         rd <= 1'b1; addr <= a;
         @(posedge clk);
         rd <= 1'b0;
         #1 cmp(name, exp, rdata);
      end
   endtask
   task pkt(input [15:0] st);
      begin
         @(posedge clk);
         hc_pkt_done <= 1'b1; hc_pkt_status <= st;
         @(posedge clk);
         hc_pkt_done <= 1'b0;
         #1;
      end
   endtask
   // A host transaction; the first fetch is checked a cycle after the start.
   task txn(input [10:0] len, input [15:0] info);
      begin
         @(posedge clk);
         hc_txn_start <= 1'b1; hc_txn_len <= len;
         @(posedge clk);
         hc_txn_start <= 1'b0;
         #1 cmp("buf_info", {16'h0, info}, {16'h0, hc_buf_info});
      end
   endtask
   task push(input [7:0] d, input ok_exp);
      integer i;
      reg ok;
      begin
         ok = 1'b0;
         @(posedge clk);
         rx_valid <= 1'b1; rx_data <= d;
         for (i = 0; i < 4 && !ok; i = i + 1) begin
            @(negedge clk);
            ok = (rx_ready === 1'b1);
            @(posedge clk);
         end
         rx_valid <= 1'b0;
         cmp("rx_taken", {31'h0, ok_exp}, {31'h0, ok});
      end
   endtask
   // Bounded wait for the link state; running out ends the run.
   task wait_link(input exp, input integer bound);
      integer i;
      begin
         for (i = 0; i < bound && connected !== exp; i = i + 1) @(posedge clk) #1;
         cmp("connected", {31'h0, exp}, {31'h0, connected});
         if (connected !== exp) end_sim;
      end
   endtask

   // ============================================================
   // Scenarios
   task t_regs;
      begin
         rchk(`UBS_ADDR_CTRL, 32'h0, "ctrl_rst");
         rchk(`UBS_ADDR_BUFCTRL, 32'h0, "bufctrl_rst");
         wreg(8'h10, 32'hffff_ffff);
         rchk(8'h10, 32'h0, "unmapped");
         wreg(`UBS_ADDR_BUFCTRL, 32'h2222_1111);
         rchk(`UBS_ADDR_BUFCTRL, 32'h2222_1111, "bufctrl");
      end
   endtask
   // Single buffered transaction of npk packets at one speed.
   task sgl(input ls, input [10:0] len, input integer npk);
      integer p;
      begin
         wreg(`UBS_ADDR_CTRL, {30'h0, ls, 1'b0});
         wreg(`UBS_ADDR_BUFCTRL, 32'hbbbb_aaaa);
         wreg(`UBS_ADDR_STATUS, 32'h8);
         txn(len, 16'haaaa);
         for (p = 0; p < npk; p = p + 1) begin
            pkt(16'h0100 + p[15:0]);
            cmp("sel_single", 32'h0, {31'h0, hc_buf_sel});
            cmp("buf_done", {31'h0, p == npk - 1}, {31'h0, hc_buf_done});
            if (p < npk - 1) rchk(`UBS_ADDR_STATUS, 32'h0, "status_mid");
         end
         rchk(`UBS_ADDR_BUFCTRL, {16'hbbbb, 16'h00ff + npk[15:0]}, "single_wb");
         rchk(`UBS_ADDR_STATUS, 32'h8, "status_end");
      end
   endtask
   task t_single;
      begin
         sgl(1'b0, 11'd100, 2);
         sgl(1'b1, 11'd9, 2);
         sgl(1'b0, 11'd64, 1);
         sgl(1'b1, 11'd8, 1);
      end
   endtask
   task t_double;
      begin
         wreg(`UBS_ADDR_CTRL, 32'h1);
         wreg(`UBS_ADDR_BUFCTRL, 32'h5555_0000);
         wreg(`UBS_ADDR_STATUS, 32'h8);
         txn(11'd16, 16'h0);
         pkt(16'h00c1);
         cmp("buf_info_d", 32'h5555, {16'h0, hc_buf_info});
         cmp("buf_done_d", 32'h1, {31'h0, hc_buf_done});
         rchk(`UBS_ADDR_STATUS, 32'ha, "status_d1");
         wreg(`UBS_ADDR_STATUS, 32'h8);
         pkt(16'h00c2);
         rchk(`UBS_ADDR_STATUS, 32'hc, "status_d2");
         rchk(`UBS_ADDR_BUFCTRL, 32'h00c2_00c1, "double_wb");
         pkt(16'h00c3);
         wreg(`UBS_ADDR_CTRL, 32'h0);
         @(posedge clk) #1 cmp("sel_back", 32'h0, {31'h0, hc_buf_sel});
      end
   endtask
   task t_link;
      begin
         wreg(`UBS_ADDR_STATUS, 32'h18);
         push(8'h99, 1'b1);
         rchk(`UBS_ADDR_STATUS, 32'h10, "status_drop");
         mode <= 2'h2;
         repeat (60) @(posedge clk);
         #1 cmp("busy_link", 32'h0, {31'h0, connected});
         mode <= 2'h0;
         repeat (IDLE_N - 2) @(posedge clk);
         #1 cmp("early_link", 32'h0, {31'h0, connected});
         wait_link(1'b1, 8);
         push(8'h11, 1'b1);
         push(8'h22, 1'b1);
         push(8'h33, 1'b0);
         rchk(`UBS_ADDR_RXDATA, 32'h11, "rx_first");
         rchk(`UBS_ADDR_RXDATA, 32'h22, "rx_second");
         rchk(`UBS_ADDR_RXDATA, 32'h0, "rx_empty");
         mode <= 2'h2;
         repeat (100) @(posedge clk);
         #1 cmp("busy_hold", 32'h1, {31'h0, connected});
         mode <= 2'h1;
         repeat (`UBS_SE0_CYCLES - 10) @(posedge clk);
         #1 cmp("se0_short", 32'h1, {31'h0, connected});
         wait_link(1'b0, 20);
         wreg(`UBS_ADDR_CTRL, 32'h0c);
         wait_link(1'b1, IDLE_N + 8);
      end
   endtask

   // Reset, then the scenarios in turn.
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_single;
      t_double;
      t_link;
      end_sim;
   end
endmodule
